// ---- design/daofp_pkg.sv ----
// Shared constants and types for the dual converter output and power block
package daofp_pkg;
  // Sample word and channels
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned RAW_W = SAMPLE_W + 1;
  localparam int unsigned CH_N = 2;
  localparam logic [SAMPLE_W-1:0] FULL_SCALE = 12'hfff;
  localparam int unsigned CH_A = 0;
  localparam int unsigned CH_B = 1;

  // Three-level pin reading and the modes it selects, same order
  typedef enum logic [1:0] {TRI_LOW, TRI_FLOAT, TRI_HIGH} daofp_tri_type;
  typedef enum logic [1:0] {FMT_OFFSET, FMT_TWOS, FMT_GRAY} daofp_fmt_type;
  typedef enum logic [1:0] {STY_CMOS, STY_DIFF_3MA, STY_DIFF_2MA} daofp_style_type;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_SLEEP, PWR_NAP} daofp_pwr_type;

  // Configuration port addresses and fields
  localparam logic [7:0] ADDR_INDEX = 8'h10;
  localparam logic [7:0] ADDR_POWER = 8'h25;
  localparam logic [7:0] ADDR_STYLE = 8'h14;
  localparam logic [7:0] ADDR_FORMAT = 8'h15;
  localparam int unsigned PWR_LSB = 1;
  localparam logic [2:0] PWR_CODE_NORMAL = 3'h1;
  localparam logic [2:0] PWR_CODE_NAP = 3'h2;
  localparam logic [2:0] PWR_CODE_SLEEP = 3'h4;
  localparam int unsigned OVR_CLR_BIT = 7;

  // Host command register offsets and fields
  localparam logic [7:0] H_CFG = 8'h00;
  localparam logic [7:0] H_WAKE = 8'h04;
  localparam logic [7:0] H_CTRL = 8'h08;
  localparam logic [7:0] H_STAT = 8'h0c;
  localparam logic [7:0] H_SAMP = 8'h10;
  localparam int unsigned WAKE_SKIP_BIT = 1;
  localparam int unsigned CTRL_KEEP_BIT = 2;
  localparam int unsigned CTRL_RECAL_BIT = 3;
  localparam int unsigned SAMP_B_LSB = 16;

  // Timing, figures in their own units
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NAP_WAKE_NS = 1000;
  localparam int unsigned SLEEP_WAKE_MS = 1;
  localparam int unsigned PS_SETUP_US = 150;
  localparam int unsigned DLL_RELOCK_US = 52;
  localparam int unsigned CAL_TIME_MS = 200;
  localparam int unsigned STROBE_PERIOD_NS = 160;
  localparam int unsigned NAP_WAKE_CYC = NAP_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_WAKE_CYC = SLEEP_WAKE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PS_SETUP_CYC = (PS_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DLL_RELOCK_CYC = DLL_RELOCK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned CAL_CYC = CAL_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned STROBE_HALF_CYC = STROBE_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int unsigned SYNC_LEAD_CYC = 4;
  localparam int unsigned RECAL_HOLD_CYC = 4;
endpackage

// ---- design/daofp_link_if.sv ----
// Pins between the converter end and the capture and configuration end
`timescale 1ns/1ps
`default_nettype none
interface daofp_link_if;
  import daofp_pkg::*;
  logic [SAMPLE_W-1:0] sample_data;
  logic                sample_data_oe;
  logic                forwarded_sample_strobe;
  logic                strobe_oe;
  logic                over_range;
  logic                over_range_oe;
  logic                port_select_n;
  logic                cfg_wr;
  logic [7:0]          cfg_addr;
  logic [7:0]          cfg_data;
  logic                recal_pull_oe;
  logic                recal_reset_n;

  // Open-drain reset line with its pull-up
  assign recal_reset_n = !recal_pull_oe;

  modport dev (
    output sample_data, sample_data_oe, forwarded_sample_strobe, strobe_oe,
    output over_range, over_range_oe,
    input  port_select_n, cfg_wr, cfg_addr, cfg_data, recal_reset_n
  );
  modport host (
    input  sample_data, sample_data_oe, forwarded_sample_strobe, strobe_oe,
    input  over_range, over_range_oe, recal_reset_n,
    output port_select_n, cfg_wr, cfg_addr, cfg_data, recal_pull_oe
  );
endinterface
`default_nettype wire

// ---- design/daofp_coder.sv ----
// Clamp, over-range detection and output coding of one sample
`timescale 1ns/1ps
`default_nettype none
module daofp_coder (
  input  wire logic [daofp_pkg::RAW_W-1:0]    raw_i,
  input  wire daofp_pkg::daofp_fmt_type       fmt_i,
  output logic [daofp_pkg::SAMPLE_W-1:0]      code_o,
  output logic                                over_o
);
  import daofp_pkg::*;

  logic [SAMPLE_W-1:0] bin;

  // Saturate instead of wrapping past the top code
  assign bin = raw_i[RAW_W-1] ? FULL_SCALE : raw_i[SAMPLE_W-1:0];
  assign over_o = (bin == FULL_SCALE);

  // Coding over the full word width
  always_comb begin
    case (fmt_i)
      FMT_TWOS: code_o = {~bin[SAMPLE_W-1], bin[SAMPLE_W-2:0]};
      FMT_GRAY: code_o = bin ^ (bin >> 1);
      default:  code_o = bin;
    endcase
  end
endmodule
`default_nettype wire

// ---- design/daofp_dev.sv ----
// Converter end: DDR sample output, coding, over-range and power states
`timescale 1ns/1ps
`default_nettype none
module daofp_dev #(
  parameter int unsigned SLEEP_CYC  = daofp_pkg::SLEEP_WAKE_CYC,
  parameter int unsigned SETUP_CYC  = daofp_pkg::PS_SETUP_CYC,
  parameter int unsigned RELOCK_CYC = daofp_pkg::DLL_RELOCK_CYC,
  parameter int unsigned CAL_LEN    = daofp_pkg::CAL_CYC,
  parameter int unsigned HALF_CYC   = daofp_pkg::STROBE_HALF_CYC
) (
  input  wire logic                            clk_sys_i,
  input  wire logic                            sys_rst_i,
  daofp_link_if.dev                            link,
  input  wire logic [daofp_pkg::RAW_W-1:0]     raw_a_i,
  input  wire logic [daofp_pkg::RAW_W-1:0]     raw_b_i,
  input  wire daofp_pkg::daofp_tri_type        output_style_pin_i,
  input  wire daofp_pkg::daofp_tri_type        power_state_pin_i,
  input  wire daofp_pkg::daofp_tri_type        number_format_pin_i,
  input  wire logic                            dll_unlock_i,
  output daofp_pkg::daofp_style_type           style_o,
  output daofp_pkg::daofp_fmt_type             fmt_o,
  output logic                                 run_a_o,
  output logic                                 run_b_o,
  output logic                                 cal_busy_o
);
  import daofp_pkg::*;

  typedef enum logic [1:0] {CH_RUN, CH_NAP, CH_SLEEP, CH_WAKE} daofp_ch_type;

  logic [1:0]          sty_meta, sty_sync, pwr_meta, pwr_sync, fmt_meta, fmt_sync;
  logic                ps_meta, ps_sync, rc_meta, rc_sync, dl_meta, dl_sync;
  logic [CH_N-1:0]     dev_index;
  logic [CH_N-1:0]     pwr_ovr;
  daofp_pwr_type       pwr_val [CH_N];
  daofp_pwr_type       tgt [CH_N];
  logic                sty_ovr, fmt_ovr;
  daofp_style_type     sty_val, sty_eff;
  daofp_fmt_type       fmt_val, fmt_eff;
  daofp_ch_type        ch_st [CH_N];
  logic [31:0]         wake_cnt [CH_N];
  logic [CH_N-1:0]     run, sleeping, napping;
  logic                dll_lost, kept_low;
  logic [31:0]         ps_low_cnt, cal_cnt, div_cnt;
  logic                cfg_ok, toggle;
  logic [2:0]          pwr_code;
  logic [RAW_W-1:0]    raw_sel;
  logic [SAMPLE_W-1:0] code;
  logic                over;
  logic                strobe, data_oe, strobe_oe, ovr, ovr_oe;
  logic [SAMPLE_W-1:0] data;

  // Two-stage synchronisers for the mode, select, recal and lock pins
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sty_meta <= 2'h0;
      sty_sync <= 2'h0;
      pwr_meta <= 2'h0;
      pwr_sync <= 2'h0;
      fmt_meta <= 2'h0;
      fmt_sync <= 2'h0;
      ps_meta  <= 1'b1;
      ps_sync  <= 1'b1;
      rc_meta  <= 1'b1;
      rc_sync  <= 1'b1;
      dl_meta  <= 1'b0;
      dl_sync  <= 1'b0;
    end else begin
      sty_meta <= output_style_pin_i;
      sty_sync <= sty_meta;
      pwr_meta <= power_state_pin_i;
      pwr_sync <= pwr_meta;
      fmt_meta <= number_format_pin_i;
      fmt_sync <= fmt_meta;
      ps_meta  <= link.port_select_n;
      ps_sync  <= ps_meta;
      rc_meta  <= link.recal_reset_n;
      rc_sync  <= rc_meta;
      dl_meta  <= dll_unlock_i;
      dl_sync  <= dl_meta;
    end
  end

  // Pin modes map in enum order; a written setting wins over the pin
  assign sty_eff = sty_ovr ? sty_val : daofp_style_type'(sty_sync);
  assign fmt_eff = fmt_ovr ? fmt_val : daofp_fmt_type'(fmt_sync);
  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      tgt[c] = pwr_ovr[c] ? pwr_val[c] : daofp_pwr_type'(pwr_sync);
      run[c] = (ch_st[c] == CH_RUN);
      sleeping[c] = (ch_st[c] == CH_SLEEP);
      napping[c] = (ch_st[c] == CH_NAP);
    end
  end

  // While asleep, writes need select low long enough or kept low
  assign cfg_ok = link.cfg_wr && !ps_sync
                  && (sleeping == '0 || kept_low || ps_low_cnt >= SETUP_CYC);
  assign pwr_code = link.cfg_data[PWR_LSB +: 3];

  // Configuration registers written over the port
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dev_index <= '0;
      pwr_ovr <= '0;
      pwr_val <= '{default: PWR_NORMAL};
      sty_ovr <= 1'b0;
      sty_val <= STY_CMOS;
      fmt_ovr <= 1'b0;
      fmt_val <= FMT_OFFSET;
    end else if (cfg_ok) begin
      case (link.cfg_addr)
        ADDR_INDEX: begin
          dev_index <= link.cfg_data[CH_N-1:0];
        end
        ADDR_POWER: begin
          // Only the selected channels take the setting
          for (int c = 0; c < CH_N; c++) begin
            if (dev_index[c]) begin
              if (pwr_code == PWR_CODE_NORMAL) begin
                pwr_ovr[c] <= 1'b1;
                pwr_val[c] <= PWR_NORMAL;
              end else if (pwr_code == PWR_CODE_NAP) begin
                pwr_ovr[c] <= 1'b1;
                pwr_val[c] <= PWR_NAP;
              end else if (pwr_code == PWR_CODE_SLEEP) begin
                pwr_ovr[c] <= 1'b1;
                pwr_val[c] <= PWR_SLEEP;
              end
            end
          end
        end
        ADDR_STYLE: begin
          sty_ovr <= !link.cfg_data[OVR_CLR_BIT];
          sty_val <= daofp_style_type'(link.cfg_data[1:0]);
        end
        ADDR_FORMAT: begin
          fmt_ovr <= !link.cfg_data[OVR_CLR_BIT];
          fmt_val <= daofp_fmt_type'(link.cfg_data[1:0]);
        end
        default: ;
      endcase
    end
  end

  // Per-channel power state with wake-up counting
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ch_st <= '{default: CH_RUN};
      wake_cnt <= '{default: 32'h0};
    end else begin
      for (int c = 0; c < CH_N; c++) begin
        case (ch_st[c])
          CH_NAP: begin
            if (tgt[c] == PWR_NORMAL) begin
              ch_st[c] <= CH_WAKE;
              wake_cnt[c] <= dll_lost ? NAP_WAKE_CYC + RELOCK_CYC : NAP_WAKE_CYC;
            end
          end
          CH_SLEEP: begin
            if (tgt[c] == PWR_NORMAL) begin
              ch_st[c] <= CH_WAKE;
              wake_cnt[c] <= SLEEP_CYC;
            end
          end
          CH_WAKE: begin
            if (wake_cnt[c] <= 32'h1) begin
              ch_st[c] <= CH_RUN;
            end else begin
              wake_cnt[c] <= wake_cnt[c] - 32'h1;
            end
          end
          default: ;
        endcase
        if (tgt[c] == PWR_NAP) begin
          ch_st[c] <= CH_NAP;
        end else if (tgt[c] == PWR_SLEEP) begin
          ch_st[c] <= CH_SLEEP;
        end
      end
    end
  end

  // Lock loss during nap lengthens recovery; set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dll_lost <= 1'b0;
    end else if (dl_sync && napping != '0) begin
      dll_lost <= 1'b1;
    end else if (run == '1) begin
      dll_lost <= 1'b0;
    end
  end

  // Select-low tracking for the sleep wake-up path
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ps_low_cnt <= 32'h0;
      kept_low <= 1'b0;
    end else begin
      if (ps_sync) begin
        ps_low_cnt <= 32'h0;
      end else if (ps_low_cnt < SETUP_CYC) begin
        ps_low_cnt <= ps_low_cnt + 32'h1;
      end
      if (sleeping == '0) begin
        kept_low <= !ps_sync;
      end else if (ps_sync) begin
        kept_low <= 1'b0;
      end
    end
  end

  // Calibration runs from reset and after each recal pulse
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cal_busy_o <= 1'b1;
      cal_cnt <= CAL_LEN;
    end else if (!rc_sync) begin
      cal_busy_o <= 1'b1;
      cal_cnt <= CAL_LEN;
    end else if (cal_busy_o) begin
      if (cal_cnt <= 32'h1) begin
        cal_busy_o <= 1'b0;
      end else begin
        cal_cnt <= cal_cnt - 32'h1;
      end
    end
  end

  // Strobe divider, stopped low while recal reset is low
  assign toggle = rc_sync && (div_cnt == HALF_CYC - 1);
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !rc_sync) begin
      div_cnt <= 32'h0;
      strobe <= 1'b0;
    end else if (toggle) begin
      div_cnt <= 32'h0;
      strobe <= !strobe;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end

  // Sample of the channel whose phase starts next
  assign raw_sel = strobe ? raw_a_i : raw_b_i;
  daofp_coder u_coder (
    .raw_i  (raw_sel),
    .fmt_i  (fmt_eff),
    .code_o (code),
    .over_o (over)
  );

  // Word and flag load at each phase start; drivers off when powered down
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      data <= '0;
      ovr <= 1'b0;
      data_oe <= 1'b0;
      strobe_oe <= 1'b0;
      ovr_oe <= 1'b0;
    end else begin
      if (toggle) begin
        data <= code;
      end
      if (!rc_sync || cal_busy_o) begin
        ovr <= 1'b1;
      end else if (toggle) begin
        ovr <= over;
      end
      data_oe <= toggle ? run[strobe ? CH_A : CH_B] : run[strobe ? CH_B : CH_A];
      strobe_oe <= run != '0;
      ovr_oe <= run != '0;
    end
  end

  // Mode and state reporting, registered
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      style_o <= STY_CMOS;
      fmt_o <= FMT_OFFSET;
      run_a_o <= 1'b0;
      run_b_o <= 1'b0;
    end else begin
      style_o <= sty_eff;
      fmt_o <= fmt_eff;
      run_a_o <= run[CH_A];
      run_b_o <= run[CH_B];
    end
  end

  // Over-range stays high while calibrating, even between sample loads
  assign link.sample_data = data;
  assign link.sample_data_oe = data_oe;
  assign link.forwarded_sample_strobe = strobe;
  assign link.strobe_oe = strobe_oe;
  assign link.over_range = ovr;
  assign link.over_range_oe = ovr_oe;
endmodule
`default_nettype wire

// ---- design/daofp_host.sv ----
// Capture and configuration end: sample decoding and wake-up sequencing
`timescale 1ns/1ps
`default_nettype none
module daofp_host #(
  parameter int unsigned SLEEP_CYC = daofp_pkg::SLEEP_WAKE_CYC,
  parameter int unsigned SETUP_CYC = daofp_pkg::PS_SETUP_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  daofp_link_if.host       link,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o
);
  import daofp_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_LEAD, HS_WRITE, HS_SETTLE} daofp_hstate_type;

  daofp_hstate_type    state;
  logic [31:0]         cnt, recal_cnt;
  logic                is_wake, woke, fresh, keep_low;
  logic [1:0]          fmt;
  logic [7:0]          pend_addr, pend_data;
  logic                ps_n, cfg_wr, recal_oe;
  logic                st_m, st_s, st_p, or_m, or_s, or_p, oe_m, oe_s;
  logic [SAMPLE_W-1:0] d_m, d_s, d_p;
  logic [SAMPLE_W-1:0] samp_a, samp_b;
  logic                or_a, or_b;

  // Rebuild offset binary from a received word
  function automatic logic [SAMPLE_W-1:0] decode(input logic [SAMPLE_W-1:0] w,
                                                 input logic [1:0] f);
    logic [SAMPLE_W-1:0] b;
    b = w;
    if (f == FMT_TWOS) begin
      b[SAMPLE_W-1] = ~w[SAMPLE_W-1];
    end else if (f == FMT_GRAY) begin
      for (int i = SAMPLE_W - 2; i >= 0; i--) begin
        b[i] = b[i+1] ^ w[i];
      end
    end
    return b;
  endfunction

  // Link pins synchronised; third stage only delays for edge finding
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      {st_m, st_s, st_p, or_m, or_s, or_p, oe_m, oe_s} <= 8'h0;
      d_m <= '0;
      d_s <= '0;
      d_p <= '0;
    end else begin
      st_m <= link.forwarded_sample_strobe;
      st_s <= st_m;
      st_p <= st_s;
      or_m <= link.over_range;
      or_s <= or_m;
      or_p <= or_s;
      oe_m <= link.sample_data_oe;
      oe_s <= oe_m;
      d_m <= link.sample_data;
      d_s <= d_m;
      d_p <= d_s;
    end
  end

  // Rising strobe ends the A phase, falling ends B; read clears fresh
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      samp_a <= '0;
      samp_b <= '0;
      or_a <= 1'b0;
      or_b <= 1'b0;
      fresh <= 1'b0;
    end else begin
      if (st_s && !st_p && oe_s) begin
        samp_a <= decode(d_p, fmt);
        or_a <= or_p;
      end
      if (!st_s && st_p && oe_s) begin
        samp_b <= decode(d_p, fmt);
        or_b <= or_p;
        fresh <= 1'b1;
      end else if (rd_i && addr_i == H_SAMP) begin
        fresh <= 1'b0;
      end
    end
  end

  // Command sequencer: select lead, one write, optional settle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= HS_IDLE;
      cnt <= 32'h0;
      is_wake <= 1'b0;
      woke <= 1'b0;
      pend_addr <= 8'h0;
      pend_data <= 8'h0;
    end else begin
      case (state)
        HS_IDLE: begin
          if (wr_i && addr_i == H_CFG) begin
            pend_addr <= wdata_i[15:8];
            pend_data <= wdata_i[7:0];
            cnt <= SYNC_LEAD_CYC;
            is_wake <= 1'b0;
            state <= HS_LEAD;
          end else if (wr_i && addr_i == H_WAKE && wdata_i[0]) begin
            pend_addr <= ADDR_POWER;
            pend_data <= 8'({PWR_CODE_NORMAL, 1'b0});
            // Device counts select-low only after its synchroniser, so lead covers both
            cnt <= wdata_i[WAKE_SKIP_BIT] ? SYNC_LEAD_CYC : SETUP_CYC + SYNC_LEAD_CYC;
            is_wake <= 1'b1;
            woke <= 1'b0;
            state <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (cnt <= 32'h1) begin
            state <= HS_WRITE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        HS_WRITE: begin
          cnt <= SLEEP_CYC;
          state <= is_wake ? HS_SETTLE : HS_IDLE;
        end
        HS_SETTLE: begin
          if (cnt <= 32'h1) begin
            woke <= 1'b1;
            state <= HS_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  // Pin drive; select rests high unless asked to stay low
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ps_n <= 1'b1;
      cfg_wr <= 1'b0;
    end else begin
      ps_n <= !(keep_low || state == HS_LEAD || state == HS_WRITE);
      cfg_wr <= (state == HS_LEAD) && (cnt <= 32'h1);
    end
  end

  // Control register and recalibration pulse
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fmt <= 2'h0;
      keep_low <= 1'b0;
      recal_oe <= 1'b0;
      recal_cnt <= 32'h0;
    end else begin
      if (wr_i && addr_i == H_CTRL) begin
        fmt <= wdata_i[1:0];
        keep_low <= wdata_i[CTRL_KEEP_BIT];
      end
      if (wr_i && addr_i == H_CTRL && wdata_i[CTRL_RECAL_BIT]) begin
        recal_oe <= 1'b1;
        recal_cnt <= RECAL_HOLD_CYC;
      end else if (recal_cnt <= 32'h1) begin
        recal_oe <= 1'b0;
      end else begin
        recal_cnt <= recal_cnt - 32'h1;
      end
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        H_CTRL: rdata_o <= 32'({keep_low, 1'b0, fmt});
        H_STAT: rdata_o <= 32'({link.recal_reset_n, woke, fresh, state != HS_IDLE});
        H_SAMP: rdata_o <= {3'h0, or_b, samp_b, 3'h0, or_a, samp_a};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  assign link.port_select_n = ps_n;
  assign link.cfg_wr = cfg_wr;
  assign link.cfg_addr = pend_addr;
  assign link.cfg_data = pend_data;
  assign link.recal_pull_oe = recal_oe;
endmodule
`default_nettype wire

// ---- bench/daofp_link_monitor.sv ----
// Checker on the link pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module daofp_link_monitor #(parameter int unsigned HALF_CYC = 20) (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic [11:0] sample_data,
  input wire logic        sample_data_oe,
  input wire logic        forwarded_sample_strobe,
  input wire logic        strobe_oe,
  input wire logic        over_range,
  input wire logic        port_select_n,
  input wire logic        cfg_wr,
  input wire logic        recal_reset_n
);
  logic [7:0] cnt;
  logic [1:0] nchg;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // Strobe edges since restart; the first one is not yet paced
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !recal_reset_n || !strobe_oe) begin
      cnt  <= 8'h00;
      nchg <= 2'h0;
    end else if ($changed(forwarded_sample_strobe)) begin
      cnt  <= 8'h00;
      nchg <= nchg + {1'b0, nchg != 2'h3};
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  a_strobe_pace: assert property ($changed(forwarded_sample_strobe) && nchg != 2'h0
    |-> cnt == HALF_CYC - 1) else $error("strobe half period wrong");
  a_over_code: assert property (nchg[1] && sample_data_oe && over_range
    |-> sample_data inside {12'hfff, 12'h7ff, 12'h800}) else $error("over range off top");
  a_data_hold: assert property (sample_data_oe && $past(sample_data_oe)
    && $changed(sample_data) |-> $changed(forwarded_sample_strobe)) else $error("word moved");
  a_strobe_recal: assert property (!recal_reset_n && !$past(recal_reset_n, 3)
    |-> !forwarded_sample_strobe) else $error("strobe high in recal");
  a_over_recal: assert property (!recal_reset_n && !$past(recal_reset_n, 3)
    |-> over_range) else $error("over range low in recal");
  a_oe_nest: assert property (sample_data_oe |-> strobe_oe)
    else $error("data driven without strobe");
  a_cfg_select: assert property (cfg_wr |-> !port_select_n)
    else $error("write without select");
  a_cfg_lead: assert property ($rose(cfg_wr) |-> $past(port_select_n, 2) == 1'b0)
    else $error("select lead too short");
endmodule
`default_nettype wire

// ---- bench/test_dual_adc_output_format_power.sv ----
// Bench joining converter end and capture end over the link
`timescale 1ns/1ps
`default_nettype none
module test_dual_adc_output_format_power;
  import daofp_pkg::*;
  localparam int SLP = 50;
  localparam int SET = 20;
  logic            clk_sys_i = 1'b0;
  logic            sys_rst_i = 1'b1;
  logic [12:0]     raw_a_i = 13'h0000;
  logic [12:0]     raw_b_i = 13'h0000;
  daofp_tri_type   output_style_pin_i = TRI_LOW;
  daofp_tri_type   power_state_pin_i = TRI_LOW;
  daofp_tri_type   number_format_pin_i = TRI_LOW;
  logic            dll_unlock_i = 1'b0;
  logic [7:0]      addr_i = 8'h00;
  logic [31:0]     wdata_i = 32'h0;
  logic            wr_i = 1'b0;
  logic            rd_i = 1'b0;
  logic [31:0]     rdata_o, rd_v, seed = 32'h5a;
  daofp_style_type style_o;
  daofp_fmt_type   fmt_o;
  logic            run_a_o, run_b_o, cal_busy_o;
  int              n_fail = 0, n_checks = 0, k;
  // Free-running system clock
  always #2 clk_sys_i = ~clk_sys_i;
  daofp_link_if link ();
  daofp_dev #(.SLEEP_CYC(SLP), .SETUP_CYC(SET), .RELOCK_CYC(10), .CAL_LEN(30)) i_daofp_dev (
    .clk_sys_i, .sys_rst_i, .link, .raw_a_i, .raw_b_i, .output_style_pin_i,
    .power_state_pin_i, .number_format_pin_i, .dll_unlock_i, .style_o, .fmt_o,
    .run_a_o, .run_b_o, .cal_busy_o);
  daofp_host #(.SLEEP_CYC(SLP), .SETUP_CYC(SET)) i_daofp_host (
    .clk_sys_i, .sys_rst_i, .link, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
  daofp_link_monitor #(.HALF_CYC(STROBE_HALF_CYC)) i_daofp_link_monitor (
    .clk_sys_i, .sys_rst_i, .sample_data(link.sample_data),
    .sample_data_oe(link.sample_data_oe), .forwarded_sample_strobe(link.forwarded_sample_strobe),
    .strobe_oe(link.strobe_oe), .over_range(link.over_range),
    .port_select_n(link.port_select_n), .cfg_wr(link.cfg_wr), .recal_reset_n(link.recal_reset_n));
  // Expected values and repeatable random words
  function logic [12:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[12:0];
  endfunction
  function logic [11:0] clamp(logic [12:0] r);
    return r[12] ? 12'hfff : r[11:0];
  endfunction
  function logic [11:0] enc(logic [11:0] c, int f);
    return (f == 0) ? c : (f == 1) ? {~c[11], c[10:0]} : c ^ (c >> 1);
  endfunction
  function logic [31:0] pair();
    return {3'h0, clamp(raw_b_i) == 12'hfff, clamp(raw_b_i),
            3'h0, clamp(raw_a_i) == 12'hfff, clamp(raw_a_i)};
  endfunction
  task final_report();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Host port cycles; wr_i or rd_i high for one clock cycle each
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task rd(logic [7:0] a);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o;
  endtask
  // Host refuses new orders while busy, so leave it room
  task cfg(logic [7:0] a, logic [7:0] d);
    wr(H_CFG, {16'h0, a, d});
    cyc(10);
  endtask
  task wait_a(int lim);
    k = 0;
    while (run_a_o !== 1'b1 && k < lim) begin
      @(negedge clk_sys_i);
      k++;
    end
    @(posedge clk_sys_i);
    if (k >= lim) begin
      n_fail++;
      final_report();
    end
  endtask
  initial begin
    cyc(10);
    sys_rst_i <= 1'b0;
    // Every format and style by pin, with full-scale and clamped words
    for (int f = 0; f < 3; f++) begin
      output_style_pin_i  <= daofp_tri_type'(f);
      number_format_pin_i <= daofp_tri_type'(f);
      wr(H_CTRL, f);
      for (int j = 0; j < 5; j++) begin
        raw_a_i <= (j == 0) ? 13'h1abc : (j == 1) ? 13'h0fff : rnd();
        raw_b_i <= (j == 1) ? 13'h1000 : rnd();
        cyc(90);
        chk(style_o, f);
        chk(fmt_o, f);
        rd(H_SAMP);
        chk(rd_v, pair());
        k = 0;
        while (link.forwarded_sample_strobe !== 1'b0 && k < 50) begin
          @(negedge clk_sys_i);
          k++;
        end
        if (k >= 50) begin
          n_fail++;
          final_report();
        end
        chk(link.sample_data, enc(clamp(raw_a_i), f));
        cyc(1);
      end
    end
    // Written modes beat the pins until released
    cfg(ADDR_FORMAT, 8'h01);
    cfg(ADDR_STYLE, 8'h00);
    chk(fmt_o, FMT_TWOS);
    chk(style_o, STY_CMOS);
    cfg(ADDR_FORMAT, 8'h80);
    chk(fmt_o, FMT_GRAY);
    // Pin nap and sleep act on both channels
    power_state_pin_i <= TRI_HIGH;
    cyc(10);
    chk({run_a_o, run_b_o, link.strobe_oe}, 0);
    power_state_pin_i <= TRI_LOW;
    wait_a(NAP_WAKE_CYC + 40);
    power_state_pin_i <= TRI_FLOAT;
    cyc(10);
    chk({run_a_o, run_b_o}, 0);
    power_state_pin_i <= TRI_LOW;
    wait_a(SLP + 40);
    // Nap of A alone, lock lost meanwhile, so wake takes longer
    cfg(ADDR_INDEX, 8'h01);
    cfg(ADDR_POWER, 8'h04);
    chk({run_a_o, run_b_o}, 1);
    dll_unlock_i <= 1'b1;
    cyc(5);
    dll_unlock_i <= 1'b0;
    cfg(ADDR_POWER, 8'h02);
    wait_a(400);
    chk(k + 5 >= NAP_WAKE_CYC + 10, 1);
    // Sleep both, wake with and without select setup
    cfg(ADDR_INDEX, 8'h03);
    cfg(ADDR_POWER, 8'h08);
    chk({link.sample_data_oe, link.strobe_oe}, 0);
    wr(H_WAKE, 1);
    wait_a(SET + SLP + 60);
    chk(k + 2 >= SET + SLP, 1);
    wr(H_CTRL, 4);
    cfg(ADDR_POWER, 8'h08);
    wr(H_WAKE, 3);
    wait_a(SLP + SET);
    chk(k + 2 >= SLP, 1);
    // Recalibration pulse, then calibration busy with over-range high until it ends
    wr(H_CTRL, 8);
    cyc(20);
    chk({cal_busy_o, link.over_range}, 3);
    cyc(100);
    chk(cal_busy_o, 0);
    final_report();
  end
endmodule
`default_nettype wire
